// *** rtl/nfl_nvm_ctrl.sv ***
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
module nfl_nvm_ctrl #(
    parameter int         PAGE_BYTES = 8,
    parameter int         EE_PAGES   = 4,
    parameter int         FUSE_COUNT = 6,
    parameter logic [47:0] FUSE_INIT = 48'hFFFF_FFFF_FFFF,
    parameter logic [3:0] FUSE_CYC   = nfl_pkg::FUSE_CYC_DEF,
    parameter logic [3:0] LOCK_CYC   = nfl_pkg::LOCK_CYC_DEF,
    parameter logic [3:0] STEP_CYC   = nfl_pkg::STEP_CYC_DEF
) (
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        CE_IN,
    input  wire logic [3:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    input  wire logic        MAP_WRITE_IN,
    input  wire logic [15:0] MAP_ADDR_IN,
    input  wire logic [7:0]  MAP_DATA_IN,
    output logic             CPU_HALT_OUT,
    output logic             NVM_BUSY_OUT,
    output logic      [7:0]  LOCK_BITS_OUT,
    output logic             FLASH_BUF_CLEAR_OUT
);
    import nfl_pkg::*;

    localparam int BYTE_W   = $clog2(PAGE_BYTES);
    localparam int EE_BYTES = PAGE_BYTES * EE_PAGES;
    localparam int EE_AW    = $clog2(EE_BYTES);

    typedef struct packed {
        nfl_state_e                   st;
        logic [15:0]                  ptr;
        logic [7:0]                   nvm_data_byte0;
        logic [6:0]                   cmd;
        logic                         map_en;
        logic [7:0]                   lock;
        logic [2:0]                   ccp_cnt;
        logic [3:0]                   wait_cnt;
        logic [EE_AW-1:0]             idx;
        logic [1:0]                   halt_cnt;
        logic                         fclr;
        logic [PAGE_BYTES-1:0]        tag;
        logic [PAGE_BYTES-1:0][7:0]   pbuf;
        logic [EE_BYTES-1:0][7:0]     mem;
    } nfl_state_s;

    nfl_state_s q;
    nfl_state_s d;

    // absolute eeprom byte from page index and byte in page
    function automatic logic [EE_AW-1:0] ee_index(input logic [15:0] p);
        ee_index = p[EE_AW-1:0];
    endfunction

    function automatic logic [7:0] fuse_byte(input logic [15:0] p);
        logic [7:0] r;
        r = ERASED_BYTE;
        for (int i = 0; i < FUSE_COUNT; i++) begin
            if (p == 16'(i)) begin
                r = FUSE_INIT[i*8 +: 8];
            end
        end
        fuse_byte = r;
    endfunction

    logic             busy;
    logic             wr_en;
    logic             exec_req;
    logic             exec_ok;
    logic             map_load;
    logic             reg_load;
    logic [EE_AW-1:0] tgt;
    logic [BYTE_W-1:0] off;
    logic             last;

    assign busy     = (q.st != ST_IDLE);
    // waitrequest only while frozen, every access is otherwise taken at once
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & ~CE_IN;
    assign wr_en    = AVS_WRITE_IN & AVS_BYTEENABLE_IN[0] & CE_IN;
    assign exec_req = wr_en & (AVS_ADDRESS_IN == REG_NVM_CONTROL_REG_A) & AVS_WRITEDATA_IN[EXEC_BIT];
    // fuse read is the only unprotected execute command
    assign exec_ok  = exec_req & ~busy
                    & ((q.cmd == CMD_READ_FUSE) | (q.ccp_cnt != 3'h0));
    assign map_load = MAP_WRITE_IN & CE_IN & q.map_en & ~busy;
    assign reg_load = wr_en & (AVS_ADDRESS_IN == REG_NVM_DATA_BYTE0) & ~busy
                    & (q.cmd == CMD_LOAD_BUF) & ~q.map_en;
    assign off      = q.idx[BYTE_W-1:0];
    // whole-eeprom erase walks every byte, page commands only one page
    assign tgt      = (q.cmd == CMD_ERASE_ALL) ? q.idx
                    : EE_AW'({ee_index(q.ptr) >> BYTE_W, off});
    assign last     = (q.cmd == CMD_ERASE_ALL) ? (q.idx == EE_AW'(EE_BYTES - 1))
                    : (q.idx == EE_AW'(PAGE_BYTES - 1));

    always_comb begin
        d = q;
        d.fclr = 1'b0;
        if (q.ccp_cnt != 3'h0) begin
            d.ccp_cnt = q.ccp_cnt - 3'h1;
        end
        if (q.halt_cnt != 2'h0) begin
            d.halt_cnt = q.halt_cnt - 2'h1;
        end
        if (wr_en && AVS_ADDRESS_IN == REG_CCP && AVS_WRITEDATA_IN[7:0] == CCP_KEY) begin
            d.ccp_cnt = CCP_WINDOW;
        end
        if (wr_en && AVS_ADDRESS_IN == REG_CTRLB) begin
            d.map_en = AVS_WRITEDATA_IN[MAPEN_BIT];
        end
        // pointer, data and command are frozen while an operation runs
        if (wr_en && !busy) begin
            if (AVS_ADDRESS_IN == REG_PTR_LO) begin
                d.ptr[7:0] = AVS_WRITEDATA_IN[7:0];
            end else if (AVS_ADDRESS_IN == REG_PTR_HI) begin
                d.ptr[15:8] = AVS_WRITEDATA_IN[7:0];
            end else if (AVS_ADDRESS_IN == REG_NVM_DATA_BYTE0) begin
                d.nvm_data_byte0 = AVS_WRITEDATA_IN[7:0];
            end else if (AVS_ADDRESS_IN == REG_CMD) begin
                d.cmd = AVS_WRITEDATA_IN[6:0];
            end
        end
        if (reg_load) begin
            d.pbuf[q.ptr[BYTE_W-1:0]] = AVS_WRITEDATA_IN[7:0];
            d.tag[q.ptr[BYTE_W-1:0]]  = 1'b1;
        end
        if (map_load) begin
            d.pbuf[MAP_ADDR_IN[BYTE_W-1:0]] = MAP_DATA_IN;
            d.tag[MAP_ADDR_IN[BYTE_W-1:0]]  = 1'b1;
            d.halt_cnt = MAP_HALT_CYC;
        end
        case (q.st)
            ST_IDLE: begin
                if (exec_ok) begin
                    d.wait_cnt = STEP_CYC - 4'h1;
                    d.idx      = '0;
                    if (q.cmd == CMD_READ_FUSE) begin
                        d.st       = ST_FUSE;
                        d.wait_cnt = FUSE_CYC - 4'h1;
                    end else if (q.cmd == CMD_WRITE_LOCK) begin
                        // no check of the code region issuing it
                        d.st       = ST_LOCK;
                        d.wait_cnt = LOCK_CYC - 4'h1;
                    end else if (q.cmd == CMD_ERASE_BUF) begin
                        d.st = ST_BUFCLR;
                    end else if (q.cmd == CMD_ERASE_PAGE || q.cmd == CMD_WRITE_PAGE
                                 || q.cmd == CMD_ERWR_PAGE || q.cmd == CMD_ERASE_ALL) begin
                        d.st = ST_PROG;
                    end else if (q.cmd == CMD_READ_EE && !q.map_en) begin
                        d.nvm_data_byte0 = q.mem[ee_index(q.ptr)];
                    end
                end
            end
            ST_FUSE: begin
                if (q.wait_cnt == 4'h0) begin
                    d.nvm_data_byte0 = fuse_byte(q.ptr);
                    d.st    = ST_IDLE;
                end else begin
                    d.wait_cnt = q.wait_cnt - 4'h1;
                end
            end
            ST_LOCK: begin
                if (q.wait_cnt == 4'h0) begin
                    // lock bits only move toward more protection
                    d.lock = q.lock & q.nvm_data_byte0;
                    d.tag  = '0;
                    d.fclr = 1'b1;
                    d.st   = ST_IDLE;
                end else begin
                    d.wait_cnt = q.wait_cnt - 4'h1;
                end
            end
            ST_BUFCLR: begin
                if (q.wait_cnt == 4'h0) begin
                    d.tag  = '0;
                    d.pbuf = '0;
                    d.st   = ST_IDLE;
                end else begin
                    d.wait_cnt = q.wait_cnt - 4'h1;
                end
            end
            ST_PROG: begin
                if (q.wait_cnt == 4'h0) begin
                    // untagged bytes are left alone, so a single byte can be programmed
                    if (q.tag[off]) begin
                        if (q.cmd == CMD_ERASE_PAGE || q.cmd == CMD_ERASE_ALL) begin
                            d.mem[tgt] = ERASED_BYTE;
                        end else if (q.cmd == CMD_WRITE_PAGE) begin
                            d.mem[tgt] = q.mem[tgt] & q.pbuf[off];
                        end else begin
                            d.mem[tgt] = q.pbuf[off];
                        end
                    end
                    d.wait_cnt = STEP_CYC - 4'h1;
                    if (last) begin
                        d.st = ST_IDLE;
                    end else begin
                        d.idx = q.idx + EE_AW'(1);
                    end
                end else begin
                    d.wait_cnt = q.wait_cnt - 4'h1;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            q         <= '0;
            q.st      <= ST_IDLE;
            q.lock    <= LOCK_RESET;
            q.mem     <= {EE_BYTES{ERASED_BYTE}};
        end else if (CE_IN) begin
            q <= d;
        end
    end

    always_comb begin
        AVS_READDATA_OUT = 32'h0000_0000;
        if (AVS_ADDRESS_IN == REG_PTR_LO) begin
            AVS_READDATA_OUT[7:0] = q.ptr[7:0];
        end else if (AVS_ADDRESS_IN == REG_PTR_HI) begin
            AVS_READDATA_OUT[7:0] = q.ptr[15:8];
        end else if (AVS_ADDRESS_IN == REG_NVM_DATA_BYTE0) begin
            AVS_READDATA_OUT[7:0] = q.nvm_data_byte0;
        end else if (AVS_ADDRESS_IN == REG_CMD) begin
            AVS_READDATA_OUT[6:0] = q.cmd;
        end else if (AVS_ADDRESS_IN == REG_CTRLB) begin
            AVS_READDATA_OUT[MAPEN_BIT] = q.map_en;
        end else if (AVS_ADDRESS_IN == REG_STATUS) begin
            AVS_READDATA_OUT[BUSY_BIT] = busy;
        end else if (AVS_ADDRESS_IN == REG_LOCK) begin
            AVS_READDATA_OUT[7:0] = q.lock;
        end
    end

    assign NVM_BUSY_OUT        = busy;
    assign CPU_HALT_OUT        = (q.st == ST_FUSE) | (q.st == ST_LOCK) | (q.halt_cnt != 2'h0);
    assign LOCK_BITS_OUT       = q.lock;
    assign FLASH_BUF_CLEAR_OUT = q.fclr;

    property p_fuse_busy;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (exec_ok && q.cmd == CMD_READ_FUSE) |=> (NVM_BUSY_OUT && CPU_HALT_OUT) [*3];
    endproperty
    a_fuse_busy: assert property (p_fuse_busy) else $error("fuse read not busy and halted");

    property p_fuse_data;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (CE_IN && q.st == ST_FUSE && q.wait_cnt == 4'h0)
            |=> (q.nvm_data_byte0 == fuse_byte($past(q.ptr))) && !NVM_BUSY_OUT;
    endproperty
    a_fuse_data: assert property (p_fuse_data) else $error("fuse byte not in nvm_data_byte0");

    property p_lock_done;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (CE_IN && q.st == ST_LOCK && q.wait_cnt == 4'h0)
            |=> (q.tag == '0) && FLASH_BUF_CLEAR_OUT
                && (LOCK_BITS_OUT == ($past(q.lock) & $past(q.nvm_data_byte0)));
    endproperty
    a_lock_done: assert property (p_lock_done) else $error("lock write did not clear buffers");

    property p_lock_halt;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (exec_ok && q.cmd == CMD_WRITE_LOCK) |=> (NVM_BUSY_OUT && CPU_HALT_OUT) [*4];
    endproperty
    a_lock_halt: assert property (p_lock_halt) else $error("lock write not busy and halted");

    property p_map_stall;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        map_load |=> CPU_HALT_OUT ##1 CPU_HALT_OUT ##1 (!CPU_HALT_OUT || !CE_IN || map_load);
    endproperty
    a_map_stall: assert property (p_map_stall) else $error("mapped load stall not two cycles");

    property p_map_blocks;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (wr_en && q.map_en && !MAP_WRITE_IN && AVS_ADDRESS_IN == REG_NVM_DATA_BYTE0
            && q.st == ST_IDLE) |=> $stable(q.tag);
    endproperty
    a_map_blocks: assert property (p_map_blocks) else $error("register load while mapped");

    property p_reg_load;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        reg_load |=> q.tag[$past(q.ptr[BYTE_W-1:0])] && !NVM_BUSY_OUT
            && (q.pbuf[$past(q.ptr[BYTE_W-1:0])] == $past(AVS_WRITEDATA_IN[7:0]));
    endproperty
    a_reg_load: assert property (p_reg_load) else $error("buffer load not stored");

    property p_ee_read;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (exec_ok && q.cmd == CMD_READ_EE && !q.map_en)
            |=> (q.nvm_data_byte0 == q.mem[ee_index(q.ptr)]) && !NVM_BUSY_OUT && !CPU_HALT_OUT;
    endproperty
    a_ee_read: assert property (p_ee_read) else $error("eeprom read wrong");

    property p_busy_ignore;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (busy && wr_en) |=> $stable(q.cmd) && $stable(q.ptr);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("write taken while busy");

    property p_buf_clear;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (exec_ok && q.cmd == CMD_ERASE_BUF) |=> NVM_BUSY_OUT ##[1:20] (q.tag == '0 && !busy);
    endproperty
    a_buf_clear: assert property (p_buf_clear) else $error("buffer clear not done");

    c_fuse:  cover property (@(posedge CLK_IN) exec_ok && q.cmd == CMD_READ_FUSE);
    c_lock:  cover property (@(posedge CLK_IN) exec_ok && q.cmd == CMD_WRITE_LOCK);
    c_map:   cover property (@(posedge CLK_IN) map_load);
    c_erwr:  cover property (@(posedge CLK_IN) q.st == ST_PROG && q.cmd == CMD_ERWR_PAGE && last);
endmodule // nfl_nvm_ctrl

// *** rtl/nfl_pkg.sv ***
package nfl_pkg;
    // register word indexes, byte address is four times the index
    localparam logic [3:0] REG_PTR_LO  = 4'h0;
    localparam logic [3:0] REG_PTR_HI  = 4'h1;
    localparam logic [3:0] REG_NVM_DATA_BYTE0   = 4'h2;
    localparam logic [3:0] REG_CMD     = 4'h3;
    localparam logic [3:0] REG_NVM_CONTROL_REG_A   = 4'h4;
    localparam logic [3:0] REG_CTRLB   = 4'h5;
    localparam logic [3:0] REG_STATUS  = 4'h6;
    localparam logic [3:0] REG_CCP     = 4'h7;
    localparam logic [3:0] REG_LOCK    = 4'h8;

    localparam int          EXEC_BIT   = 0;
    localparam int          MAPEN_BIT  = 0;
    localparam int          BUSY_BIT   = 7;

    localparam logic [6:0] CMD_NOP        = 7'h00;
    localparam logic [6:0] CMD_READ_FUSE  = 7'h07;
    localparam logic [6:0] CMD_WRITE_LOCK = 7'h08;
    localparam logic [6:0] CMD_LOAD_BUF   = 7'h33;
    localparam logic [6:0] CMD_ERASE_BUF  = 7'h36;
    localparam logic [6:0] CMD_ERASE_PAGE = 7'h32;
    localparam logic [6:0] CMD_WRITE_PAGE = 7'h34;
    localparam logic [6:0] CMD_ERWR_PAGE  = 7'h35;
    localparam logic [6:0] CMD_ERASE_ALL  = 7'h30;
    localparam logic [6:0] CMD_READ_EE    = 7'h06;

    // unlock key value is arbitrary
    localparam logic [7:0] CCP_KEY        = 8'hA5;
    localparam logic [2:0] CCP_WINDOW     = 3'h4;
    localparam logic [7:0] LOCK_RESET     = 8'hFF;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [1:0] MAP_HALT_CYC   = 2'h2;
    localparam logic [3:0] FUSE_CYC_DEF   = 4'h3;
    localparam logic [3:0] LOCK_CYC_DEF   = 4'h4;
    localparam logic [3:0] STEP_CYC_DEF   = 4'h2;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FUSE   = 3'b001,
        ST_LOCK   = 3'b010,
        ST_BUFCLR = 3'b011,
        ST_PROG   = 3'b100
    } nfl_state_e;
endpackage

// *** tb/nfl_cpu_model.sv ***
`timescale 1ns/10ps
module nfl_cpu_model (
    input  wire logic        clk_in,
    input  wire logic        wait_in,
    input  wire logic [31:0] rdata_in,
    output logic      [3:0]  addr_out,
    output logic             rd_out,
    output logic             wr_out,
    output logic      [31:0] wdata_out,
    output logic             tmo_out
);
    import nfl_pkg::*;
    logic [31:0] last_rd;
    initial begin
        addr_out = 4'h0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        tmo_out = 1'b0;
        last_rd = 32'h0;
    end
    // one bus cycle, held until waitrequest is sampled low; bounded so a stuck slave ends the run
    task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        addr_out <= a;
        wr_out <= w;
        rd_out <= !w;
        wdata_out <= {24'h0, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_in !== 1'b0 && n < 64);
        last_rd = rdata_in;
        if (wait_in !== 1'b0) tmo_out <= 1'b1;
        wr_out <= 1'b0;
        rd_out <= 1'b0;
    endtask
endmodule // nfl_cpu_model

// *** tb/nfl_nvm_ctrl_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module nfl_nvm_ctrl_tb;
    import nfl_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        map_w = 1'b0;
    logic [15:0] map_a = 16'h0;
    logic [7:0]  map_d = 8'h0;
    logic [3:0]  adr;
    logic        rd, wr, wreq, halt, busy, fclr, tmo;
    logic [31:0] wdat, rdat, ex;
    logic [7:0]  lockb;
    logic [31:0] q[$];
    logic [7:0]  ee[32], bf[8];
    logic        tg[8];
    int          n_mismatch = 0, compares = 0, nb, nh, nf;

    always #10 clk = ~clk;

    nfl_nvm_ctrl #(.FUSE_INIT(48'h5A5A_5A5A_5A5A)) uut (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'h1),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
        .MAP_WRITE_IN(map_w), .MAP_ADDR_IN(map_a), .MAP_DATA_IN(map_d),
        .CPU_HALT_OUT(halt), .NVM_BUSY_OUT(busy), .LOCK_BITS_OUT(lockb),
        .FLASH_BUF_CLEAR_OUT(fclr));
    nfl_cpu_model cpu (
        .clk_in(clk), .wait_in(wreq), .rdata_in(rdat), .addr_out(adr),
        .rd_out(rd), .wr_out(wr), .wdata_out(wdat), .tmo_out(tmo));

    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge tmo) begin
        n_mismatch++;
        end_sim();
    end

    // results are judged here, in request order
    always @(posedge clk) begin
        if (rd === 1'b1 && wreq === 1'b0) begin
            ex = (q.size() > 0) ? q.pop_front() : 32'hXXXXXXXX;
            `CHK("readdata", ex, rdat)
        end
    end

    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        cpu.xfer(a, 1'b0, 8'h00);
    endtask

    task automatic run(input logic [6:0] c, input logic key, input logic poke);
        cpu.xfer(REG_CMD, 1'b1, {1'b0, c});
        if (key) cpu.xfer(REG_CCP, 1'b1, CCP_KEY);
        cpu.xfer(REG_NVM_CONTROL_REG_A, 1'b1, 8'h01);
        if (poke) cpu.xfer(REG_PTR_LO, 1'b1, 8'h1F);
        nb = 0;
        nh = 0;
        nf = 0;
        for (int i = 0; i < 2000; i++) begin
            @(negedge clk);
            nb += (busy === 1'b1);
            nh += (halt === 1'b1);
            nf += (fclr === 1'b1);
            if (i > 2 && busy === 1'b0) break;
        end
        if (busy !== 1'b0) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic page(input int p);
        for (int b = 0; b < 8; b++) begin
            cpu.xfer(REG_PTR_LO, 1'b1, 8'(p * 8 + b));
            run(CMD_READ_EE, 1'b1, 1'b0);
            `CHK("rd_busy", 0, nb)
            rdchk(REG_NVM_DATA_BYTE0, ee[p * 8 + b]);
        end
    endtask

    // reference update: only tagged slots take part
    task automatic pgcmd(input logic [6:0] c, input int p, input logic poke);
        cpu.xfer(REG_PTR_LO, 1'b1, 8'(p * 8));
        run(c, 1'b1, poke);
        `CHK("pg_busy", 1'b1, nb > 0)
        `CHK("pg_halt", 0, nh)
        for (int b = 0; b < 32; b++) begin
            if (tg[b % 8] && (c == CMD_ERASE_ALL || b / 8 == p)) begin
                if (c == CMD_WRITE_PAGE) ee[b] = ee[b] & bf[b % 8];
                else if (c == CMD_ERWR_PAGE) ee[b] = bf[b % 8];
                else ee[b] = ERASED_BYTE;
            end
        end
    endtask

    initial begin
        ee = '{default: 8'hFF};
        bf = '{default: 8'h00};
        tg = '{default: 1'b0};
        void'($urandom(70657));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(REG_LOCK, LOCK_RESET);
        rdchk(REG_STATUS, 8'h00);
        rdchk(4'h9, 8'h00);
        // frozen clock enable: the write must wait out waitrequest and still land
        fork
            cpu.xfer(REG_PTR_LO, 1'b1, 8'h42);
            begin
                @(posedge clk);
                ce <= 1'b0;
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        rdchk(REG_PTR_LO, 8'h42);
        for (int f = 2; f < 8; f += 4) begin
            cpu.xfer(REG_PTR_LO, 1'b1, 8'(f));
            run(CMD_READ_FUSE, 1'b0, 1'b0);
            `CHK("fuse_busy", 1'b1, nb > 0)
            `CHK("fuse_halt", 1'b1, nh > 0)
            rdchk(REG_NVM_DATA_BYTE0, (f < 6) ? 8'h5A : 8'hFF);
        end
        cpu.xfer(REG_CMD, 1'b1, {1'b0, CMD_LOAD_BUF});
        for (int b = 0; b < 4; b++) begin
            bf[b] = 8'($urandom);
            tg[b] = 1'b1;
            cpu.xfer(REG_PTR_LO, 1'b1, 8'(8 + b));
            cpu.xfer(REG_NVM_DATA_BYTE0, 1'b1, bf[b]);
            @(negedge clk);
            `CHK("ld_busy", 1'b0, busy)
        end
        cpu.xfer(REG_PTR_LO, 1'b1, 8'h08);
        run(CMD_WRITE_PAGE, 1'b0, 1'b0);
        `CHK("nokey_busy", 0, nb)
        pgcmd(CMD_WRITE_PAGE, 1, 1'b0);
        page(1);
        pgcmd(CMD_ERWR_PAGE, 2, 1'b1);
        rdchk(REG_PTR_LO, 8'h10);
        page(2);
        pgcmd(CMD_ERASE_PAGE, 1, 1'b0);
        page(1);
        pgcmd(CMD_ERASE_ALL, 0, 1'b0);
        page(2);
        run(CMD_ERASE_BUF, 1'b1, 1'b0);
        `CHK("bclr_busy", 1'b1, nb > 0)
        tg = '{default: 1'b0};
        pgcmd(CMD_WRITE_PAGE, 3, 1'b0);
        page(3);
        // mapped store: page bits of the address must not steer the slot
        cpu.xfer(REG_CTRLB, 1'b1, 8'h01);
        bf[5] = 8'($urandom);
        tg[5] = 1'b1;
        @(posedge clk);
        map_w <= 1'b1;
        map_a <= 16'h10ED;
        map_d <= bf[5];
        @(posedge clk);
        map_w <= 1'b0;
        nh = 0;
        repeat (4) begin
            @(negedge clk);
            nh += (halt === 1'b1);
        end
        `CHK("map_halt", 2, nh)
        cpu.xfer(REG_CMD, 1'b1, {1'b0, CMD_LOAD_BUF});
        cpu.xfer(REG_PTR_LO, 1'b1, 8'h00);
        cpu.xfer(REG_NVM_DATA_BYTE0, 1'b1, 8'h77);
        run(CMD_READ_EE, 1'b1, 1'b0);
        rdchk(REG_NVM_DATA_BYTE0, 8'h77);
        cpu.xfer(REG_CTRLB, 1'b1, 8'h00);
        pgcmd(CMD_WRITE_PAGE, 0, 1'b0);
        page(0);
        cpu.xfer(REG_NVM_DATA_BYTE0, 1'b1, 8'h3C);
        run(CMD_WRITE_LOCK, 1'b1, 1'b0);
        `CHK("lock_busy", 1'b1, nb > 0)
        `CHK("lock_halt", 1'b1, nh > 0)
        `CHK("flash_clr", 1, nf)
        rdchk(REG_LOCK, 8'h3C);
        `CHK("lock_bits", 8'h3C, lockb)
        tg = '{default: 1'b0};
        pgcmd(CMD_WRITE_PAGE, 3, 1'b0);
        page(3);
        end_sim();
    end
endmodule // nfl_nvm_ctrl_tb
